// File: rsio_regs.vh
// Register offsets, field positions, reset values and codes of the reader status I/O block
// Behaviour
// RULE1: The block has exactly four status outputs and two control inputs.
// RULE2: Each of the first three outputs carries one selectable function, and which functions are allowed depends on the output index.
// RULE3: An output set to read success is on while the last read succeeded.
// RULE4: An output set to read failure is on while the last read failed.
// RULE5: An output set to busy is on for the whole symbol reading operation.
// RULE6: Verification pass and fail outputs follow the good or bad verification result.
// RULE7: Stability pass is on below the threshold and stability fail at or above it.
// RULE8: Print quality pass is on below the threshold and print quality fail at or above it.
// RULE9: The fourth output is on exactly for the configured exposure time of each capture.
// RULE10: Each of the four outputs can be disabled and then stays off.
// RULE11: The first input starts a reading and the second stops it, the stop acting on an edge only.
// RULE12: Start and stop inputs can each be disabled and are then ignored.
// RULE13: Both inputs are synchronised before edge detection so each transition gives one pulse.
// RULE14: The controller holds each input level for several clock cycles.
`ifndef RSIO_REGS_VH
`define RSIO_REGS_VH

// Word offsets on the bus (byte addresses)
`define RSIO_ADR_CTRL      8'h00
`define RSIO_ADR_FUNC      8'h04
`define RSIO_ADR_THRESH    8'h08
`define RSIO_ADR_EXPO      8'h0C
`define RSIO_ADR_STATUS    8'h10
`define RSIO_ADR_IRQSTAT   8'h14
`define RSIO_ADR_IRQMASK   8'h18

// Control register fields
`define RSIO_CTRL_OUTEN_LSB   0
`define RSIO_CTRL_STARTEN_BIT 4
`define RSIO_CTRL_STOPEN_BIT  5

// Reset values
`define RSIO_CTRL_RST    32'h0000_003F
`define RSIO_FUNC_RST    32'h0000_0321
`define RSIO_THRESH_RST  32'h0000_3232
`define RSIO_EXPO_RST    32'h0000_0064

// Output function codes
`define RSIO_FN_OFF       4'h0
`define RSIO_FN_READOK    4'h1
`define RSIO_FN_READNG    4'h2
`define RSIO_FN_BUSY      4'h3
`define RSIO_FN_VEROK     4'h4
`define RSIO_FN_VERNG     4'h5
`define RSIO_FN_STABOK    4'h6
`define RSIO_FN_STABNG    4'h7
`define RSIO_FN_PQOK      4'h8
`define RSIO_FN_PQNG      4'h9

// Interrupt event bits
`define RSIO_EV_START     0
`define RSIO_EV_STOP      1
`define RSIO_EV_DONE      2
`define RSIO_EV_EXPEND    3
`define RSIO_EV_NUM       4

`endif

// File: rsio_sync.v
// Three-stage input synchroniser with agreement filter
`timescale 1ns/100ps
module rsio_sync (
   input  wire mclk,
   input  wire sys_rst,
   input  wire clkEn,
   input  wire pinIn,
   output wire syncOut
);
   reg stage1_reg;
   reg stage2_reg;
   reg stage3_reg;
   reg level_reg;

   // Level changes only once stages two and three agree
   always @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         stage1_reg <= 1'b0;
         stage2_reg <= 1'b0;
         stage3_reg <= 1'b0;
         level_reg  <= 1'b0;
      end else if (clkEn) begin
         stage1_reg <= pinIn;
         stage2_reg <= stage1_reg;
         stage3_reg <= stage2_reg;
         if (stage2_reg == stage3_reg) begin // RULE13
            level_reg <= stage3_reg;
         end
      end
   end

   assign syncOut = level_reg;
endmodule

// File: rsio_top.v
// Reader status I/O block: four status outputs, two control inputs, Wishbone registers
`timescale 1ns/100ps
`include "rsio_regs.vh"
module rsio_top (
   input  wire        mclk,
   input  wire        sys_rst,
   input  wire        clkEn,
   // Wishbone classic slave
   input  wire        wb_cyc_i,
   input  wire        wb_stb_i,
   input  wire        wb_we_i,
   input  wire [7:0]  wb_adr_i,
   input  wire [3:0]  wb_sel_i,
   input  wire [31:0] wb_dat_i,
   output wire [31:0] wb_dat_o,
   output wire        wb_ack_o,
   output wire        irq,
   // Reading engine side
   input  wire        readBusy,
   input  wire        readDone,
   input  wire        readOk,
   input  wire        verifyOk,
   input  wire [7:0]  stabilityValue,
   input  wire [7:0]  qualityValue,
   input  wire        captureStart,
   output wire        readStartPulse,
   output wire        readStopPulse,
   // External pins
   input  wire        read_start_input,
   input  wire        read_stop_input,
   output wire        status_output_a,
   output wire        status_output_b,
   output wire        status_output_c,
   output wire        flash_sync_output
);

   // Byte-lane merge for register writes
   function [31:0] mergeBytes;
      input [31:0] oldVal;
      input [31:0] newVal;
      input [3:0]  sel;
      integer      i;
      begin
         mergeBytes = oldVal;
         for (i = 0; i < 4; i = i + 1) begin
            if (sel[i]) begin
               mergeBytes[i*8 +: 8] = newVal[i*8 +: 8];
            end
         end
      end
   endfunction

   // Which function codes each output index accepts
   function funcAllowed;
      input [1:0] idx;
      input [3:0] code;
      begin
         if (idx == 2'd0) begin
            funcAllowed = (code >= `RSIO_FN_READOK) && (code <= `RSIO_FN_VERNG);
         end else begin
            funcAllowed = (code >= `RSIO_FN_READOK) && (code <= `RSIO_FN_PQNG);
         end
      end
   endfunction

   // Level of an output given its index, code, enable and the condition set
   function outLevel;
      input [1:0]  idx;
      input [3:0]  code;
      input        enable;
      input [15:0] cond;
      begin
         outLevel = enable && funcAllowed(idx, code) && cond[code];
      end
   endfunction

   // Configuration and status registers
   reg [31:0] ctrl_reg;
   reg [31:0] func_reg;
   reg [31:0] thresh_reg;
   reg [31:0] expo_reg;
   reg [`RSIO_EV_NUM-1:0] irqStat_reg;
   reg [`RSIO_EV_NUM-1:0] irqMask_reg;
   reg [31:0] datO_reg;
   reg        ack_reg;
   reg        irq_reg;

   // Latched result of the last read
   reg        resValid_reg;
   reg        resOk_reg;
   reg        resVer_reg;
   reg [7:0]  resStab_reg;
   reg [7:0]  resQual_reg;
   reg        busyD_reg;

   // Input edge detection and pulses
   reg        startLvlD_reg;
   reg        stopLvlD_reg;
   reg        startPulse_reg;
   reg        stopPulse_reg;

   // Exposure counter and outputs
   reg [15:0] expCnt_reg;
   reg        outA_reg;
   reg        outB_reg;
   reg        outC_reg;
   reg        flash_reg;

   wire       startLvl;
   wire       stopLvl;
   wire       busAccess;
   wire       busWrite;
   wire [7:0] wordAdr;
   wire       startEdge;
   wire       stopEdge;
   wire       busyRise;
   wire [15:0] cond;
   wire [`RSIO_EV_NUM-1:0] events;
   wire [`RSIO_EV_NUM-1:0] w1cBits;
   wire       stabBelow;
   wire       qualBelow;
   wire       expEnd;
   reg  [15:0] expCnt_next;
   reg  [31:0] readData;

   // Pin synchronisers
   rsio_sync startSync (
      .mclk    (mclk),
      .sys_rst (sys_rst),
      .clkEn   (clkEn),
      .pinIn   (read_start_input),
      .syncOut (startLvl)
   );

   rsio_sync stopSync (
      .mclk    (mclk),
      .sys_rst (sys_rst),
      .clkEn   (clkEn),
      .pinIn   (read_stop_input),
      .syncOut (stopLvl)
   );

   // Bus decode: one access per request, answered the next edge
   assign busAccess = wb_cyc_i && wb_stb_i && !ack_reg;
   assign busWrite  = busAccess && wb_we_i;
   assign wordAdr   = {2'b00, wb_adr_i[7:2]};

   // Rising edges of synchronised inputs, gated by their enables
   assign startEdge = startLvl && !startLvlD_reg
                      && ctrl_reg[`RSIO_CTRL_STARTEN_BIT]; // RULE11 RULE12
   assign stopEdge  = stopLvl && !stopLvlD_reg
                      && ctrl_reg[`RSIO_CTRL_STOPEN_BIT]; // RULE11 RULE12
   assign busyRise  = readBusy && !busyD_reg;

   // Threshold comparisons
   assign stabBelow = resStab_reg < thresh_reg[7:0];
   assign qualBelow = resQual_reg < thresh_reg[15:8];

   // Condition set indexed by function code
   assign cond[0]  = 1'b0;
   assign cond[1]  = resValid_reg && resOk_reg;            // RULE3
   assign cond[2]  = resValid_reg && !resOk_reg;           // RULE4
   assign cond[3]  = readBusy;                             // RULE5
   assign cond[4]  = resValid_reg && resVer_reg;           // RULE6
   assign cond[5]  = resValid_reg && !resVer_reg;          // RULE6
   assign cond[6]  = resValid_reg && stabBelow;            // RULE7
   assign cond[7]  = resValid_reg && !stabBelow;           // RULE7
   assign cond[8]  = resValid_reg && qualBelow;            // RULE8
   assign cond[9]  = resValid_reg && !qualBelow;           // RULE8
   assign cond[15:10] = 6'h00;

   // Exposure counter next value
   always @* begin
      expCnt_next = expCnt_reg;
      if (captureStart) begin
         expCnt_next = expo_reg[15:0]; // RULE9
      end else if (expCnt_reg != 16'h0000) begin
         expCnt_next = expCnt_reg - 16'h0001;
      end
   end
   assign expEnd = !captureStart && (expCnt_reg == 16'h0001);

   // Interrupt events and write-one-to-clear mask
   assign events[`RSIO_EV_START]  = startEdge;
   assign events[`RSIO_EV_STOP]   = stopEdge;
   assign events[`RSIO_EV_DONE]   = readDone;
   assign events[`RSIO_EV_EXPEND] = expEnd;
   assign w1cBits = (busWrite && wordAdr == `RSIO_ADR_IRQSTAT >> 2 && wb_sel_i[0])
                    ? wb_dat_i[`RSIO_EV_NUM-1:0] : {`RSIO_EV_NUM{1'b0}};

   // Read multiplexer
   always @* begin
      readData = 32'h0000_0000;
      case (wordAdr)
         `RSIO_ADR_CTRL >> 2: begin
            readData = ctrl_reg;
         end
         `RSIO_ADR_FUNC >> 2: begin
            readData = func_reg;
         end
         `RSIO_ADR_THRESH >> 2: begin
            readData = thresh_reg;
         end
         `RSIO_ADR_EXPO >> 2: begin
            readData = expo_reg;
         end
         `RSIO_ADR_STATUS >> 2: begin
            readData = {20'h0_0000, resValid_reg, resOk_reg, resVer_reg, readBusy,
                        stopLvl, startLvl, 2'b00,
                        flash_reg, outC_reg, outB_reg, outA_reg};
         end
         `RSIO_ADR_IRQSTAT >> 2: begin
            readData = {28'h000_0000, irqStat_reg};
         end
         `RSIO_ADR_IRQMASK >> 2: begin
            readData = {28'h000_0000, irqMask_reg};
         end
         default: begin
            readData = 32'h0000_0000;
         end
      endcase
   end

   // Bus slave and configuration registers
   always @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         ctrl_reg    <= `RSIO_CTRL_RST;
         func_reg    <= `RSIO_FUNC_RST;
         thresh_reg  <= `RSIO_THRESH_RST;
         expo_reg    <= `RSIO_EXPO_RST;
         irqMask_reg <= {`RSIO_EV_NUM{1'b0}};
         datO_reg    <= 32'h0000_0000;
         ack_reg     <= 1'b0;
      end else if (clkEn) begin
         ack_reg <= busAccess;
         if (busAccess && !wb_we_i) begin
            datO_reg <= readData;
         end
         if (busWrite) begin
            case (wordAdr)
               `RSIO_ADR_CTRL >> 2: begin
                  ctrl_reg <= mergeBytes(ctrl_reg, wb_dat_i, wb_sel_i) & 32'h0000_003F;
               end
               `RSIO_ADR_FUNC >> 2: begin
                  func_reg <= mergeBytes(func_reg, wb_dat_i, wb_sel_i) & 32'h0000_0FFF;
               end
               `RSIO_ADR_THRESH >> 2: begin
                  thresh_reg <= mergeBytes(thresh_reg, wb_dat_i, wb_sel_i) & 32'h0000_FFFF;
               end
               `RSIO_ADR_EXPO >> 2: begin
                  expo_reg <= mergeBytes(expo_reg, wb_dat_i, wb_sel_i) & 32'h0000_FFFF;
               end
               `RSIO_ADR_IRQMASK >> 2: begin
                  if (wb_sel_i[0]) begin
                     irqMask_reg <= wb_dat_i[`RSIO_EV_NUM-1:0];
                  end
               end
               default: begin
                  ctrl_reg <= ctrl_reg;
               end
            endcase
         end
      end
   end

   // Sticky interrupt status, set wins over clear, and the level output
   always @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         irqStat_reg <= {`RSIO_EV_NUM{1'b0}};
         irq_reg     <= 1'b0;
      end else if (clkEn) begin
         irqStat_reg <= (irqStat_reg & ~w1cBits) | events;
         irq_reg     <= |(((irqStat_reg & ~w1cBits) | events) & irqMask_reg);
      end
   end

   // Input edges, start and stop pulses to the reading engine
   always @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         startLvlD_reg  <= 1'b0;
         stopLvlD_reg   <= 1'b0;
         startPulse_reg <= 1'b0;
         stopPulse_reg  <= 1'b0;
      end else if (clkEn) begin
         startLvlD_reg  <= startLvl;
         stopLvlD_reg   <= stopLvl;
         startPulse_reg <= startEdge; // RULE11
         stopPulse_reg  <= stopEdge;  // RULE11
      end
   end

   // Result latch: taken at read completion, dropped when a new read starts
   always @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         busyD_reg    <= 1'b0;
         resValid_reg <= 1'b0;
         resOk_reg    <= 1'b0;
         resVer_reg   <= 1'b0;
         resStab_reg  <= 8'h00;
         resQual_reg  <= 8'h00;
      end else if (clkEn) begin
         busyD_reg <= readBusy;
         if (readDone) begin
            resValid_reg <= 1'b1;
            resOk_reg    <= readOk;
            resVer_reg   <= verifyOk;
            resStab_reg  <= stabilityValue;
            resQual_reg  <= qualityValue;
         end else if (busyRise) begin
            resValid_reg <= 1'b0;
         end
      end
   end

   // Status outputs and the exposure-synchronous flash output
   always @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         expCnt_reg <= 16'h0000;
         outA_reg   <= 1'b0;
         outB_reg   <= 1'b0;
         outC_reg   <= 1'b0;
         flash_reg  <= 1'b0;
      end else if (clkEn) begin
         expCnt_reg <= expCnt_next;
         outA_reg   <= outLevel(2'd0, func_reg[3:0], ctrl_reg[0], cond);  // RULE2 RULE10
         outB_reg   <= outLevel(2'd1, func_reg[7:4], ctrl_reg[1], cond);  // RULE2 RULE10
         outC_reg   <= outLevel(2'd2, func_reg[11:8], ctrl_reg[2], cond); // RULE2 RULE10
         flash_reg  <= ctrl_reg[3] && (expCnt_next != 16'h0000);        // RULE9 RULE10
      end
   end

   // Port drive, straight from flip-flops
   assign wb_dat_o          = datO_reg;
   assign wb_ack_o          = ack_reg;
   assign irq               = irq_reg;
   assign readStartPulse    = startPulse_reg;
   assign readStopPulse     = stopPulse_reg;
   assign status_output_a   = outA_reg;  // RULE1
   assign status_output_b   = outB_reg;  // RULE1
   assign status_output_c   = outC_reg;  // RULE1
   assign flash_sync_output = flash_reg; // RULE1
endmodule

// File: rsio_props.sv
// Port assertions of the reader status I/O block
`timescale 1ns/100ps
module rsio_props (
   input wire        mclk,
   input wire        sys_rst,
   input wire        clkEn,
   input wire        wb_cyc_i,
   input wire        wb_stb_i,
   input wire        wb_we_i,
   input wire [31:0] wb_dat_o,
   input wire        wb_ack_o,
   input wire        captureStart,
   input wire        read_start_input,
   input wire        read_stop_input,
   input wire        readStartPulse,
   input wire        readStopPulse,
   input wire        flash_sync_output
);
   default clocking @(posedge mclk); endclocking
   default disable iff (sys_rst);
   // Bus answer one cycle after a taken request, one cycle long
   ack_timely_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && clkEn |=> wb_ack_o)
      else $error("late ack");
   ack_single_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("long ack");
   ack_cause_a: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
      else $error("stray ack");
   data_held_a: assert property ($changed(wb_dat_o) |-> wb_ack_o && !$past(wb_we_i))
      else $error("read data moved");
   // Pin events only from a synchronised rising level that was held
   start_edge_a:
      assert property (readStartPulse |-> read_start_input && $past(read_start_input, 3))
      else $error("start event without held edge");
   stop_edge_a:
      assert property (readStopPulse |-> read_stop_input && $past(read_stop_input, 3))
      else $error("stop event without held edge");
   start_once_a: assert property (readStartPulse |=> !readStartPulse [*6])
      else $error("start event repeated");
   stop_once_a: assert property (readStopPulse |=> !readStopPulse [*6])
      else $error("stop event repeated");
   flash_cause_a: assert property ($rose(flash_sync_output) |-> $past(captureStart))
      else $error("flash without capture");
   // Main scenarios reached
   start_c: cover property (readStartPulse);
   flash_c: cover property ($fell(flash_sync_output));
   read_c: cover property (wb_ack_o && !wb_we_i);
endmodule
bind rsio_top rsio_props chk (.mclk, .sys_rst, .clkEn, .wb_cyc_i, .wb_stb_i, .wb_we_i,
   .wb_dat_o, .wb_ack_o, .captureStart, .read_start_input, .read_stop_input,
   .readStartPulse, .readStopPulse, .flash_sync_output);

// File: rsio_ctrl_model.sv
// External controller model that drives the two trigger pins
`timescale 1ns/100ps
module rsio_ctrl_model (
   input  wire       mclk,
   input  wire       doStart,
   input  wire       doStop,
   input  wire [5:0] holdCyc,
   output wire       read_start_input,
   output wire       read_stop_input
);
   reg [6:0] startCnt = 7'h00;
   reg [6:0] stopCnt = 7'h00;
   // Each request holds a pin high holdCyc cycles, then low as long
   always @(posedge mclk) begin
      if (doStart && startCnt == 7'h00)
         startCnt <= {holdCyc, 1'b0};
      else if (startCnt != 7'h00)
         startCnt <= startCnt - 7'h01;
      if (doStop && stopCnt == 7'h00)
         stopCnt <= {holdCyc, 1'b0};
      else if (stopCnt != 7'h00)
         stopCnt <= stopCnt - 7'h01;
   end
   assign read_start_input = startCnt > {1'b0, holdCyc};
   assign read_stop_input  = stopCnt > {1'b0, holdCyc};
endmodule

// File: rsio_top_test.sv
// Self-checking bench of the reader status I/O block
`timescale 1ns/100ps
`include "rsio_regs.vh"
module rsio_top_test;
   reg         mclk = 1'b0;
   reg         sys_rst = 1'b1;
   reg         clkEn = 1'b1;
   reg  [3:0]  wbSel = 4'hF;
   reg         wb_cyc_i = 1'b0;
   reg         wb_we_i = 1'b0;
   reg  [7:0]  wb_adr_i = 8'h00;
   reg  [31:0] wb_dat_i = 32'h0000_0000;
   reg         readBusy = 1'b0;
   reg         readDone = 1'b0;
   reg         readOk = 1'b0;
   reg         verifyOk = 1'b0;
   reg  [7:0]  stabilityValue = 8'h00;
   reg  [7:0]  qualityValue = 8'h00;
   reg         captureStart = 1'b0;
   reg         doStart = 1'b0;
   reg         doStop = 1'b0;
   reg  [5:0]  holdCyc = 6'h08;
   wire [31:0] wb_dat_o;
   wire        wb_ack_o, irq, readStartPulse, readStopPulse, read_start_input;
   wire        read_stop_input, status_output_a, status_output_b, status_output_c;
   wire        flash_sync_output;
   integer     n_mismatch = 0, n_tests = 0, nStart = 0, nStop = 0, nFlash = 0;
   integer     cycles = 0, c, k, s0;
   reg  [31:0] expQ [$];
   reg  [31:0] rstVal [0:7] = '{`RSIO_CTRL_RST, `RSIO_FUNC_RST, `RSIO_THRESH_RST,
      `RSIO_EXPO_RST, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000};

   initial forever #2 mclk = ~mclk;

   rsio_top uut (.mclk, .sys_rst, .clkEn, .wb_cyc_i, .wb_stb_i(wb_cyc_i), .wb_we_i,
      .wb_adr_i, .wb_sel_i(wbSel), .wb_dat_i, .wb_dat_o, .wb_ack_o, .irq, .readBusy,
      .readDone, .readOk, .verifyOk, .stabilityValue, .qualityValue, .captureStart,
      .readStartPulse, .readStopPulse, .read_start_input, .read_stop_input,
      .status_output_a, .status_output_b, .status_output_c, .flash_sync_output);
   rsio_ctrl_model ctrl (.mclk, .doStart, .doStop, .holdCyc, .read_start_input,
      .read_stop_input);

   task check(input [31:0] seen, input [31:0] exp);
      begin
         n_tests = n_tests + 1;
         if (seen !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
         end
      end
   endtask

   task complete_run;
      begin
         $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
         if (n_mismatch == 0 && n_tests > 0)
            $display("NO MISMATCHES");
         else
            $display("MISMATCHES SEEN");
         $finish;
      end
   endtask

   // One classic cycle, held until ack is sampled, then a idle cycle
   task wb(input w, input [7:0] a, input [31:0] d);
      begin
         wb_cyc_i <= 1'b1;
         wb_we_i <= w;
         wb_adr_i <= a;
         wb_dat_i <= d;
         @(posedge mclk);
         while (wb_ack_o !== 1'b1)
            @(posedge mclk);
         wb_cyc_i <= 1'b0;
         @(posedge mclk);
      end
   endtask

   task rd(input [7:0] a, input [31:0] e);
      begin
         expQ.push_back(e);
         wb(1'b0, a, 32'h0000_0000);
      end
   endtask

   // One-cycle strobe of capture, done, start request, stop request
   task tick(input [3:0] p);
      begin
         {doStop, doStart, readDone, captureStart} <= p;
         @(posedge mclk);
         {doStop, doStart, readDone, captureStart} <= 4'h0;
      end
   endtask

   function expOut(input [1:0] idx, input [3:0] code);
      begin
         case (code)
            4'h1: expOut = readOk;
            4'h2: expOut = !readOk;
            4'h3: expOut = readBusy;
            4'h4: expOut = verifyOk;
            4'h5: expOut = !verifyOk;
            4'h6: expOut = stabilityValue < 8'h32;
            4'h7: expOut = stabilityValue >= 8'h32;
            4'h8: expOut = qualityValue < 8'h32;
            4'h9: expOut = qualityValue >= 8'h32;
            default: expOut = 1'b0;
         endcase
         if (idx == 2'd0 && code > 4'h5)
            expOut = 1'b0;
      end
   endfunction

   // Read data scoreboard, pin event counters and the hang limit
   always @(posedge mclk) begin
      cycles <= cycles + 1;
      nStart <= nStart + (readStartPulse === 1'b1);
      nStop <= nStop + (readStopPulse === 1'b1);
      nFlash <= nFlash + (flash_sync_output === 1'b1);
      if (wb_ack_o === 1'b1 && wb_we_i === 1'b0)
         check(wb_dat_o, expQ.pop_front());
      if (cycles == 6000) begin
         n_mismatch = n_mismatch + 1;
         complete_run;
      end
   end

   initial begin
      void'($urandom(79956));
      repeat (3) @(posedge mclk);
      sys_rst <= 1'b0;
      @(posedge mclk);
      for (k = 0; k < 8; k = k + 1)
         rd(8'(k * 4), rstVal[k]);
      $display("reset values done");
      // Every function code on a, b, c: boundary round, then a random one
      for (k = 0; k < 2; k = k + 1) begin
         readBusy <= 1'b1;
         repeat (4) @(posedge mclk);
         readBusy <= 1'b0;
         {verifyOk, readOk, qualityValue, stabilityValue} <= k ? 18'($urandom) : 18'h1_3132;
         tick(4'h2);
         repeat (2) @(posedge mclk);
         for (c = 0; c < 10; c = c + 1) begin
            wb(1'b1, `RSIO_ADR_FUNC, {20'h0_0000, c[3:0], c[3:0], c[3:0]});
            @(negedge mclk);
            check(status_output_a, expOut(2'd0, c[3:0]));
            check(status_output_b, expOut(2'd1, c[3:0]));
            check(status_output_c, expOut(2'd2, c[3:0]));
            @(posedge mclk);
         end
      end
      $display("output functions done");
      // Flash window of the programmed exposure and its end event
      wb(1'b1, `RSIO_ADR_EXPO, 32'h0000_0005);
      wb(1'b1, `RSIO_ADR_IRQSTAT, 32'h0000_000F);
      s0 = nFlash;
      tick(4'h1);
      repeat (10) @(posedge mclk);
      @(negedge mclk);
      check(nFlash - s0, 5);
      @(posedge mclk);
      rd(`RSIO_ADR_IRQSTAT, 32'h0000_0008);
      // Clock enable low for 4 cycles stretches the 5-cycle window to 9
      s0 = nFlash;
      tick(4'h1);
      clkEn <= 1'b0;
      repeat (4) @(posedge mclk);
      clkEn <= 1'b1;
      repeat (10) @(posedge mclk);
      @(negedge mclk);
      check(nFlash - s0, 9);
      @(posedge mclk);
      $display("flash done");
      // Busy follows the engine; disabled outputs and inputs stay quiet
      wb(1'b1, `RSIO_ADR_FUNC, 32'h0000_0333);
      readBusy <= 1'b1;
      repeat (3) @(posedge mclk);
      @(negedge mclk);
      check(status_output_a, 1'b1);
      @(posedge mclk);
      wb(1'b1, `RSIO_ADR_CTRL, 32'h0000_0000);
      s0 = nStart;
      tick(4'hC);
      repeat (20) @(posedge mclk);
      tick(4'h1);
      repeat (3) @(posedge mclk);
      @(negedge mclk);
      check({status_output_a, status_output_b, status_output_c}, 3'h0);
      check(flash_sync_output, 1'b0);
      check(nStart - s0, 0);
      check(nStop, 0);
      repeat (8) @(posedge mclk);
      $display("disable done");
      // Start edge sets the event and interrupt; write one clears it
      readBusy <= 1'b0;
      wb(1'b1, `RSIO_ADR_CTRL, 32'h0000_003F);
      wb(1'b1, `RSIO_ADR_IRQSTAT, 32'h0000_000F);
      wb(1'b1, `RSIO_ADR_IRQMASK, 32'h0000_0003);
      tick(4'h4);
      repeat (12) @(posedge mclk);
      @(negedge mclk);
      check(nStart - s0, 1);
      check(irq, 1'b1);
      @(posedge mclk);
      rd(`RSIO_ADR_IRQSTAT, 32'h0000_0001);
      wb(1'b1, `RSIO_ADR_IRQSTAT, 32'h0000_0001);
      rd(`RSIO_ADR_IRQSTAT, 32'h0000_0000);
      // Stop held high a long time gives one event only
      holdCyc <= 6'h1E;
      tick(4'h8);
      repeat (70) @(posedge mclk);
      @(negedge mclk);
      check(nStop, 1);
      check(irq, 1'b1);
      @(posedge mclk);
      wb(1'b1, `RSIO_ADR_IRQMASK, 32'h0000_0000);
      @(negedge mclk);
      check(irq, 1'b0);
      $display("inputs and interrupt done");
      @(posedge mclk);
      // Byte lane write: only the selected lane of the threshold changes
      wbSel <= 4'h2;
      wb(1'b1, `RSIO_ADR_THRESH, 32'h0000_4100);
      wbSel <= 4'hF;
      rd(`RSIO_ADR_THRESH, 32'h0000_4132);
      $display("byte lanes done");
      complete_run;
   end
endmodule
